/* power_mode_pkg.sv */
// Shared constants for the power-mode and wake controller
package power_mode_pkg;
    // Register byte addresses on the AXI4-Lite port
    localparam logic [7:0]  MISC_ADDR       = 8'h20;
    localparam logic [7:0]  STAT_ADDR       = 8'h24;
    // Clock control register fields and reset value
    localparam int          SLOW_EN_BIT     = 0;
    localparam int          DIV_LO_BIT      = 1;
    localparam int          DIV_HI_BIT      = 2;
    localparam int          CLK_OUT_BIT     = 5;
    localparam logic [7:0]  MISC_RESET      = 8'h00;
    localparam logic [7:0]  MISC_WMASK      = 8'h27;
    // Status register fields
    localparam int          ST_WAIT_BIT     = 0;
    localparam int          ST_HALT_BIT     = 1;
    localparam int          ST_START_BIT    = 2;
    localparam int          ST_SLOW_BIT     = 3;
    localparam int          ST_IMASK_BIT    = 4;
    localparam int          ST_PEND_LSB     = 8;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    // Source indices, highest rank first after reset and trap
    localparam int          NUM_SRC         = 10;
    localparam logic [9:0]  WAKE_MASK       = 10'h1e3;
    localparam logic [15:0] VEC_RESET       = 16'hfffe;
    localparam logic [15:0] VEC_TRAP        = 16'hfffc;
    localparam logic [15:0] VEC_FIRST       = 16'hfffa;
    localparam logic [15:0] VEC_SCI         = 16'hffe4;
    localparam int          SCI_IDX         = 9;
    // Oscillator start-up wait, in CPU cycles
    localparam int          STARTUP_CYCLES  = 4096;
    // Half period minus one, in oscillator cycles, for divide by 2
    localparam logic [3:0]  HALF_RUN_M1     = 4'h0;
endpackage

/* power_mode_wake_controller.sv */
// Power-mode, clock divider, interrupt ranking and wake controller
// What this block does
// - Each source has a fixed vector; reset top, trap, externals, peripherals, serial last.
// - Only reset, external lines, reload timer and op-amp events wake from HALT.
// - After reset the block is in RUN with CPU clock at oscillator over two.
// - Slow enable picks oscillator over 4, 8, 16 or 32 from two select bits.
// - WAIT entered during SLOW keeps the slow division in force.
// - Wait instruction stops the CPU while peripherals stay clocked.
// - During WAIT the interrupt mask is forced to zero.
// - WAIT ends on interrupt or reset, branching to the matching routine.
// - Servicing pushes condition codes, sets the mask, pop restores it.
// - Halt instruction stops the oscillator, CPU and all peripherals.
// - HALT exit restarts the oscillator and waits 4096 CPU cycles first.
// - HALT entry clears the mask; a pending waking interrupt wakes at once.
// - Watchdog-halt option decides whether HALT with watchdog on resets.
// - Simultaneous pending interrupts are served highest rank first.
// - Maskable ones need the mask clear; trap is served regardless.
`timescale 1ns/1ps
module power_mode_wake_controller #(
    parameter int STARTUP_CYCLES = power_mode_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // CPU core instruction events, one-cycle pulses, and the popped mask value
    input  wire logic        wait_for_interrupt_instr,
    input  wire logic        halt_instr,
    input  wire logic        trap_instr,
    input  wire logic        mask_set,
    input  wire logic        mask_clear,
    input  wire logic        cc_pop,
    input  wire logic        cc_pop_mask,
    // Interrupt sources: pins and peripheral flags
    input  wire logic        external_irq_line_a,
    input  wire logic        external_irq_line_b,
    input  wire logic [7:0]  periph_irq,
    // Watchdog option and state
    input  wire logic        watchdog_halt_option,
    input  wire logic        watchdog_enabled,
    // Clocking outputs
    output logic             osc_enable,
    output logic             cpu_tick,
    output logic             periph_tick,
    output logic             cpu_running,
    output logic             clock_out,
    // Interrupt service outputs
    output logic             cc_push,
    output logic             irq_take,
    output logic [15:0]      vector_addr,
    output logic             mask_bit,
    output logic             watchdog_reset
);
    typedef enum logic [1:0] {RUN, WAIT, HALT, STARTUP} mode_e;

    mode_e       mode_r, mode_nxt;
    logic [7:0]  misc_r;
    logic [3:0]  cnt_r, cur_half_r;
    logic        clk_r, cpu_tick_r, periph_tick_r;
    logic [12:0] start_cnt_r;
    logic [2:0]  sync_a_r, sync_b_r;
    logic [1:0]  ext_pend_r;
    logic        imask_r, take_r, push_r, wdg_r, boot_r;
    logic [15:0] vec_r;
    logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0]  wstrb_r;
    logic [1:0]  bresp_r, rresp_r;

    // Rank index to vector: two bytes per rank, serial source sits lower
    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        if (idx == 4'(power_mode_pkg::SCI_IDX)) begin
            vec_of = power_mode_pkg::VEC_SCI;
        end else begin
            vec_of = power_mode_pkg::VEC_FIRST - {11'h000, idx, 1'b0};
        end
    endfunction

    // Lowest set index is the highest rank
    function automatic logic [3:0] first_set(input logic [9:0] v);
        first_set = 4'h0;
        for (int i = power_mode_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    // Pin synchronisers; only stages 1 and 2 are read by logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
        end else begin
            sync_a_r <= {sync_a_r[1:0], external_irq_line_a};
            sync_b_r <= {sync_b_r[1:0], external_irq_line_b};
        end
    end

    // Pending sources, external lines are edge latched
    wire [1:0]  ext_rise  = {sync_b_r[1] & ~sync_b_r[2], sync_a_r[1] & ~sync_a_r[2]};
    wire [9:0]  pend      = {periph_irq, ext_pend_r};
    wire        pend_any  = |pend;
    wire [9:0]  wake_src  = pend & power_mode_pkg::WAKE_MASK;
    wire        wake_any  = |wake_src;
    wire [3:0]  top_idx   = first_set(pend);
    wire        slow_on   = misc_r[power_mode_pkg::SLOW_EN_BIT];
    wire [1:0]  div_sel   = {misc_r[power_mode_pkg::DIV_HI_BIT],
                             misc_r[power_mode_pkg::DIV_LO_BIT]};

    // Service decision; trap ignores the mask
    wire        in_run    = (mode_r == RUN);
    wire        take_trap = in_run && trap_instr;
    wire        take_irq  = in_run && !trap_instr && pend_any && !imask_r;
    wire        take_any  = take_trap || take_irq;
    wire [1:0]  ext_clr   = (take_irq && top_idx < 4'h2) ?
                            (top_idx[0] ? 2'b10 : 2'b01) : 2'b00;

    // Set wins over the clear issued by taking the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_pend_r <= 2'b00;
        end else begin
            ext_pend_r <= (ext_pend_r & ~ext_clr) | ext_rise;
        end
    end

    // Half period of the selected division, minus one
    wire [3:0]  sel_half  = slow_on ? 4'((5'h02 << div_sel) - 5'h01)
                                    : power_mode_pkg::HALF_RUN_M1;
    wire        osc_on    = (mode_r != HALT);
    wire        half_end  = (cnt_r == cur_half_r);
    wire        rise      = osc_on && half_end && !clk_r;

    // Divider: new ratio is loaded only at a rising boundary, so no runt pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r      <= 4'h0;
            cur_half_r <= power_mode_pkg::HALF_RUN_M1;
            clk_r      <= 1'b0;
        end else if (osc_on) begin
            cnt_r <= half_end ? 4'h0 : cnt_r + 4'h1;
            if (half_end) begin
                clk_r <= ~clk_r;
            end
            if (rise) begin
                cur_half_r <= sel_half;
            end
        end
    end

    // Clock ticks: CPU only in RUN, peripherals in RUN and WAIT, slow kept in WAIT
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_tick_r    <= 1'b0;
            periph_tick_r <= 1'b0;
        end else begin
            cpu_tick_r    <= rise && in_run;
            periph_tick_r <= rise && (in_run || mode_r == WAIT);
        end
    end

    // Mode sequencing
    wire        wdg_hit   = halt_instr && watchdog_enabled && !watchdog_halt_option;
    wire        start_end = rise && (start_cnt_r == 13'(STARTUP_CYCLES - 1));
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            RUN: begin
                if (take_any) begin
                    mode_nxt = RUN;
                end else if (halt_instr && !wdg_hit && !wake_any) begin
                    mode_nxt = HALT;
                end else if (wait_for_interrupt_instr) begin
                    mode_nxt = WAIT;
                end
            end
            WAIT: begin
                if (pend_any) begin
                    mode_nxt = RUN;
                end
            end
            HALT: begin
                if (wake_any) begin
                    mode_nxt = STARTUP;
                end
            end
            STARTUP: begin
                if (start_end) begin
                    mode_nxt = RUN;
                end
            end
            default: mode_nxt = RUN;
        endcase
    end

    // Mode register and start-up counter of CPU cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r      <= RUN;
            start_cnt_r <= 13'h0000;
        end else begin
            mode_r      <= mode_nxt;
            if (mode_r != STARTUP) begin
                start_cnt_r <= 13'h0000;
            end else if (rise) begin
                start_cnt_r <= start_cnt_r + 13'h0001;
            end
        end
    end

    // Interrupt mask: take sets it, low-power entry and WAIT force it clear
    wire        lp_entry  = in_run && !take_any &&
                            (wait_for_interrupt_instr || (halt_instr && !wdg_hit));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imask_r <= 1'b1;
        end else if (take_any) begin
            imask_r <= 1'b1;
        end else if (lp_entry || mode_r == WAIT || mode_r == HALT) begin
            imask_r <= 1'b0;
        end else if (cc_pop) begin
            imask_r <= cc_pop_mask;
        end else if (mask_set) begin
            imask_r <= 1'b1;
        end else if (mask_clear) begin
            imask_r <= 1'b0;
        end
    end

    // Service strobes and vector; reset vector is offered once after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            take_r <= 1'b0;
            push_r <= 1'b0;
            wdg_r  <= 1'b0;
            boot_r <= 1'b1;
            vec_r  <= power_mode_pkg::VEC_RESET;
        end else begin
            boot_r <= 1'b0;
            take_r <= take_any || boot_r;
            push_r <= take_any;
            wdg_r  <= in_run && !take_any && wdg_hit;
            if (take_trap) begin
                vec_r <= power_mode_pkg::VEC_TRAP;
            end else if (take_irq) begin
                vec_r <= vec_of(top_idx);
            end
        end
    end

    // AXI4-Lite decode
    wire        wr_go     = aw_got_r && w_got_r && !bvalid_r;
    wire        wr_misc   = (awaddr_r == power_mode_pkg::MISC_ADDR);
    wire        rd_misc   = (s_axi_araddr == power_mode_pkg::MISC_ADDR);
    wire        rd_stat   = (s_axi_araddr == power_mode_pkg::STAT_ADDR);
    wire        rd_go     = s_axi_arvalid && !rvalid_r;
    wire [31:0] stat_word = (32'(pend) << power_mode_pkg::ST_PEND_LSB)
                          | (32'(imask_r) << power_mode_pkg::ST_IMASK_BIT)
                          | (32'(slow_on) << power_mode_pkg::ST_SLOW_BIT)
                          | (32'(mode_r == STARTUP) << power_mode_pkg::ST_START_BIT)
                          | (32'(mode_r == HALT) << power_mode_pkg::ST_HALT_BIT)
                          | (32'(mode_r == WAIT) << power_mode_pkg::ST_WAIT_BIT);
    wire [31:0] rd_word   = rd_misc ? {24'h000000, misc_r} :
                            rd_stat ? stat_word : 32'h00000000;

    // Write path: address and data taken in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= power_mode_pkg::RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h00000000;
            wstrb_r  <= 4'h0;
            misc_r   <= power_mode_pkg::MISC_RESET;
        end else begin
            if (s_axi_awvalid && !aw_got_r && !bvalid_r) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_r && !bvalid_r) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_misc ? power_mode_pkg::RESP_OKAY
                                    : power_mode_pkg::RESP_SLVERR;
                if (wr_misc && wstrb_r[0]) begin
                    misc_r <= wdata_r[7:0] & power_mode_pkg::MISC_WMASK;
                end
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read path: address taken when no answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= power_mode_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= (rd_misc || rd_stat) ? power_mode_pkg::RESP_OKAY
                                             : power_mode_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Output drive; ready signals decoded from the valid inputs, osc_enable, cpu_running and clock_out decoded from registers, the rest straight from flip-flops
    assign s_axi_awready = s_axi_awvalid && !aw_got_r && !bvalid_r ? 1'b1 : 1'b0;
    assign s_axi_wready  = s_axi_wvalid && !w_got_r && !bvalid_r ? 1'b1 : 1'b0;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign osc_enable    = (mode_r != HALT);
    assign cpu_tick      = cpu_tick_r;
    assign periph_tick   = periph_tick_r;
    assign cpu_running   = (mode_r == RUN);
    assign clock_out     = clk_r && misc_r[power_mode_pkg::CLK_OUT_BIT];
    assign cc_push       = push_r;
    assign irq_take      = take_r;
    assign vector_addr   = vec_r;
    assign mask_bit      = imask_r;
    assign watchdog_reset = wdg_r;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_halted;
        mode_r == HALT;
    endsequence
    sequence s_woke;
        ##1 mode_r == STARTUP;
    endsequence

    property p_wake_only_allowed;
        s_halted and (wake_src == 10'h000) |=> mode_r != STARTUP;
    endproperty
    a_wake_only_allowed: assert property (p_wake_only_allowed)
        else $error("HALT left without an allowed wake source");

    property p_wake_goes_startup;
        s_halted and wake_any |-> s_woke;
    endproperty
    a_wake_goes_startup: assert property (p_wake_goes_startup)
        else $error("allowed wake did not start oscillator wait");

    property p_startup_len;
        (mode_r == STARTUP) && (mode_nxt == RUN) |-> start_cnt_r == 13'(STARTUP_CYCLES - 1);
    endproperty
    a_startup_len: assert property (p_startup_len)
        else $error("start-up wait ended at wrong count");

    property p_mask_wait;
        mode_r == WAIT |-> !imask_r;
    endproperty
    a_mask_wait: assert property (p_mask_wait)
        else $error("mask set during WAIT");

    property p_halt_off;
        // Ticks launched on the entry edge belong to the last RUN cycle
        mode_r == HALT && $past(mode_r) == HALT |-> !osc_enable && !cpu_tick && !periph_tick;
    endproperty
    a_halt_off: assert property (p_halt_off)
        else $error("clocks running in HALT");

    property p_wait_cpu_stop;
        mode_r == WAIT && $past(mode_r) == WAIT |-> !cpu_tick_r;
    endproperty
    a_wait_cpu_stop: assert property (p_wait_cpu_stop)
        else $error("CPU clocked during WAIT");

    property p_take_sets_mask;
        take_any |=> imask_r && cc_push && irq_take;
    endproperty
    a_take_sets_mask: assert property (p_take_sets_mask)
        else $error("service did not push and mask");

    property p_trap_vec;
        take_trap |=> vector_addr == power_mode_pkg::VEC_TRAP;
    endproperty
    a_trap_vec: assert property (p_trap_vec)
        else $error("trap vector wrong");

    property p_masked_no_take;
        in_run && imask_r && !trap_instr |-> !take_any;
    endproperty
    a_masked_no_take: assert property (p_masked_no_take)
        else $error("masked interrupt serviced");

    property p_wdg_halt;
        in_run && !take_any && wdg_hit |=> watchdog_reset && mode_r == RUN;
    endproperty
    a_wdg_halt: assert property (p_wdg_halt)
        else $error("watchdog halt option ignored");

    property p_run_div2;
        !slow_on && cur_half_r == 4'h0 && rise |-> ##2 (rise || mode_r == HALT);
    endproperty
    a_run_div2: assert property (p_run_div2)
        else $error("RUN clock not oscillator over two");
endmodule

/* cpu_core_model.sv */
// CPU core model: runs each interrupt or trap routine and returns from it; the reset vector gets no return
`timescale 1ns/1ps
module cpu_core_model #(
    parameter int SVC = 6
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Service start from the controller
    input  wire logic        irq_take,
    input  wire logic [15:0] vector_addr,
    // Return from interrupt
    output logic             cc_pop,
    output logic             cc_pop_mask
);
    logic [7:0] cnt_r;
    // Routine lasts SVC cycles, then pops the saved mask, clear on entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
            cc_pop <= 1'b0;
            cc_pop_mask <= 1'b1;
        end else begin
            if (irq_take && vector_addr != 16'hfffe) cnt_r <= 8'(SVC);
            else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
            cc_pop <= (cnt_r == 8'h01);
            // Popped value means nothing without the pulse, so it toggles
            cc_pop_mask <= (cnt_r == 8'h01) ? 1'b0 : ~cc_pop_mask;
        end
    end
endmodule

/* power_mode_wake_controller_tb.sv */
// Self-checking bench for the power-mode and wake controller
`timescale 1ns/1ps
module power_mode_wake_controller_tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, external_irq_line_a, external_irq_line_b, watchdog_halt_option;
    logic        watchdog_enabled, osc_enable, cpu_tick, periph_tick, cpu_running, clock_out;
    logic        cc_push, irq_take, mask_bit, watchdog_reset, cc_pop, cc_pop_mask;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, periph_irq;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [4:0]  ev;
    logic [15:0] vector_addr;
    int          num_errors = 0, n_tests = 0, cyc = 0, n;
    // Short start-up count keeps the halt exit quick
    power_mode_wake_controller #(.STARTUP_CYCLES(8)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .wait_for_interrupt_instr(ev[0]), .halt_instr(ev[1]),
        .trap_instr(ev[2]), .mask_set(ev[3]), .mask_clear(ev[4]), .cc_pop, .cc_pop_mask,
        .external_irq_line_a, .external_irq_line_b, .periph_irq, .watchdog_halt_option,
        .watchdog_enabled, .osc_enable, .cpu_tick, .periph_tick, .cpu_running,
        .clock_out, .cc_push, .irq_take, .vector_addr, .mask_bit, .watchdog_reset);
    cpu_core_model cpu (.aclk, .aresetn, .irq_take, .vector_addr, .cc_pop, .cc_pop_mask);
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return irq_take;
            1: return periph_tick;
            2: return clock_out;
            3: return cpu_running;
            4: return cpu_tick;
            default: return watchdog_reset;
        endcase
    endfunction
    // Wait for a signal, bounded; n returns the cycles taken
    task automatic wsig(input int w);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (sig(w) !== 1'b1 && n < 300);
    endtask
    task automatic count(input int w, input int c);
        n = 0;
        repeat (c) begin
            @(posedge aclk);
            n += int'(sig(w) === 1'b1);
        end
    endtask
    task automatic pulse(input int k);
        @(posedge aclk);
        ev <= 5'(1 << k);
        @(posedge aclk);
        ev <= 5'h00;
    endtask
    task automatic wtake(input logic [15:0] v);
        wsig(0);
        chk("take", 1, irq_take);
        chk("push", 1, cc_push);
        chk("vector", {16'h0, v}, {16'h0, vector_addr});
    endtask
    // Bus master: both write channels offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    // Scenarios
    task automatic t_reset;
        // Reset fetch offers the vector but pushes nothing
        wsig(0);
        chk("boot take", 1, irq_take);
        chk("boot no push", 0, cc_push);
        chk("boot vector", 32'hfffe, {16'h0, vector_addr});
        chk("run", 1, cpu_running);
        wsig(4);
        wsig(4);
        chk("run div", 2, n);
    endtask
    task automatic t_regs;
        axw(power_mode_pkg::MISC_ADDR, 32'hff);
        axr(power_mode_pkg::MISC_ADDR);
        chk("misc", 32'h27, rd);
        axr(8'h40);
        chk("unmapped rd", 2, rs);
        axw(8'h40, 32'h1);
        chk("unmapped wr", 2, rs);
    endtask
    // Each divider code with clock out on; 64 cycles hold whole periods
    task automatic t_slow;
        for (int s = 0; s < 4; s++) begin
            axw(power_mode_pkg::MISC_ADDR, 32'h21 | 32'(s << 1));
            wsig(4);
            wsig(4);
            wsig(4);
            chk("slow div", 4 << s, n);
            count(2, 64);
            chk("clock out", 32, n);
        end
    endtask
    task automatic t_wait;
        pulse(0);
        wsig(1);
        wsig(1);
        chk("slow wait div", 32, n);
        chk("cpu stopped", 0, cpu_running);
        chk("wait mask", 0, mask_bit);
        external_irq_line_a <= 1'b1;
        wtake(16'hfffa);
        external_irq_line_a <= 1'b0;
        axw(power_mode_pkg::MISC_ADDR, 32'h0);
    endtask
    task automatic t_rank;
        pulse(3);
        periph_irq <= 8'hff;
        pulse(4);
        for (int i = 0; i < 8; i++) begin
            wtake(i == 7 ? 16'hffe4 : 16'hfff6 - 16'(2 * i));
            periph_irq[i] <= 1'b0;
        end
    endtask
    // Masked pending edge: no service, and halt must not stick
    task automatic t_mask;
        // Let the last routine return first, or its pop would unmask
        count(0, 10);
        pulse(3);
        external_irq_line_a <= 1'b1;
        count(0, 20);
        chk("masked", 0, n);
        external_irq_line_a <= 1'b0;
        // Halt clears the mask, so the latched edge is served at once
        pulse(1);
        wtake(16'hfffa);
        chk("halt pending", 1, osc_enable & cpu_running);
        pulse(2);
        wtake(16'hfffc);
    endtask
    task automatic t_halt;
        count(0, 10);
        pulse(1);
        count(0, 3);
        chk("osc off", 0, osc_enable);
        chk("halt mask", 0, mask_bit);
        periph_irq <= 8'h01;
        count(1, 20);
        chk("halt ticks", 0, n);
        chk("no wake", 0, osc_enable | cpu_running);
        axr(power_mode_pkg::STAT_ADDR);
        chk("status", 32'h00000402, rd);
        periph_irq <= 8'h00;
        external_irq_line_b <= 1'b1;
        wsig(3);
        chk("startup", 1, n >= 16 && n < 40);
        wtake(16'hfff8);
        external_irq_line_b <= 1'b0;
    endtask
    task automatic t_wdg;
        {watchdog_enabled, watchdog_halt_option} <= 2'b10;
        pulse(1);
        wsig(5);
        chk("wdg reset", 1, watchdog_reset);
        chk("osc kept", 1, osc_enable);
        watchdog_halt_option <= 1'b1;
        pulse(1);
        count(0, 3);
        chk("wdg halts", 0, osc_enable);
        external_irq_line_a <= 1'b1;
        wtake(16'hfffa);
        {external_irq_line_a, watchdog_enabled} <= 2'b00;
    endtask
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, periph_irq, ev} = '0;
        {external_irq_line_a, external_irq_line_b, watchdog_enabled} = '0;
        {watchdog_halt_option, s_axi_wstrb} = 5'h0f;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_regs();
        t_slow();
        t_wait();
        t_rank();
        t_mask();
        t_halt();
        t_wdg();
        summarize();
    end
endmodule
